// ### inc/rx_deframer_pkg.sv
package rx_deframer_pkg;
   typedef enum logic [1:0] {MODE_SYNC, MODE_HDLC, MODE_UART} rx_mode_t;
   typedef enum logic [1:0] {U_IDLE, U_DATA, U_PARITY, U_STOP} uart_state_t;
   // shared buffer map
   localparam logic [4:0]  STATUS0_ADDR = 5'h00;
   localparam logic [4:0]  DATA0_ADDR   = 5'h01;
   localparam logic [4:0]  STATUS1_ADDR = 5'h09;
   localparam logic [4:0]  DATA1_ADDR   = 5'h0a;
   localparam logic [7:0]  STATUS_RESET = 8'h00;
   localparam logic [7:0]  BYTE_RESET   = 8'h00;
   localparam logic [3:0]  FULL_BYTES   = 4'h8;
   localparam logic [3:0]  ONE_CHAR     = 4'h1;
   localparam logic [6:0]  ACC_BITS     = 7'h40;
   // status fields
   localparam logic [1:0]  ERR_NONE     = 2'h0;
   localparam logic [1:0]  ERR_CRC      = 2'h1;
   localparam logic [1:0]  ERR_ALIGN    = 2'h2;
   localparam logic [1:0]  ERR_ABORT    = 2'h3;
   localparam logic [1:0]  ERR_PARITY   = 2'h1;
   localparam logic [1:0]  ERR_STOP     = 2'h2;
   localparam logic [1:0]  ERR_BREAK    = 2'h3;
   localparam int          SYSTEM_ERROR_BYTE_RX_BIT = 1;
   localparam logic [7:0]  SYSTEM_ERROR_BYTE_RESET = 8'h00;
   localparam logic [7:0]  CLEAR_RX_ARG = 8'h02;
   // hdlc bit layer
   localparam logic [3:0]  STUFF_ONES   = 4'h5;
   localparam logic [3:0]  FLAG_ONES    = 4'h6;
   localparam logic [3:0]  ABORT_ONES   = 4'h7;
   localparam logic [3:0]  HUNT_ONES    = 4'h8;
   localparam logic [4:0]  FLAG_TAIL    = 5'h06;
   localparam logic [4:0]  LINE_BITS    = 5'h16;
   localparam int          CRC_TAP      = 16;
   localparam logic [2:0]  ALIGN_PHASE  = 3'h6;
   localparam logic [15:0] CRC_INIT     = 16'hffff;
   localparam logic [15:0] CRC_POLY     = 16'h8408;
   localparam logic [15:0] CRC_GOOD     = 16'hf0b8;
endpackage : rx_deframer_pkg

// ### verif/host_model.sv
`timescale 1ns/100ps
module host_model
   import rx_deframer_pkg::*;
(
   input  wire logic       clk,         // clock
   input  wire logic       receive_irq, // buffer ready
   input  wire logic [7:0] host_rdata,  // read data
   input  wire logic       do_init,     // run init
   input  wire logic       auto_clear,  // free buffers
   output logic            host_we,     // write strobe
   output logic      [4:0] host_addr,   // address
   output logic      [7:0] host_wdata,  // write data
   output logic            rx_init,     // init done
   output logic      [7:0] last_status, // status seen
   output logic      [7:0] last_data,   // first byte
   output int              n_seen       // buffers served
);
   logic       idx;
   logic [4:0] sa;
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      host_addr  = a;
      host_wdata = d;
      host_we    = 1'b1;
      @(negedge clk);
      host_we = 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge clk);
      host_addr = a;
      @(negedge clk);
      d = host_rdata;
   endtask : rd
   initial begin
      {host_we, host_addr, host_wdata, rx_init, idx, last_status, last_data} = '0;
      n_seen = 0;
      forever begin
         @(posedge clk);
         #1;
         if (do_init) begin
            idx = 1'b0;
            wr(STATUS0_ADDR, 8'h00);
            wr(STATUS1_ADDR, 8'h00);
            @(negedge clk);
            rx_init = 1'b1;
            @(negedge clk);
            rx_init = 1'b0;
         end else if (receive_irq) begin
            sa = idx ? STATUS1_ADDR : STATUS0_ADDR;
            rd(sa, last_status);
            rd(sa + 5'h01, last_data);
            if (auto_clear)
               wr(sa, 8'h00);
            idx = ~idx;
            n_seen++;
         end
      end
   end
endmodule : host_model

// ### verif/rx_parallel_buffer_deframer_tb.sv
`timescale 1ns/100ps
module rx_parallel_buffer_deframer_tb
   import rx_deframer_pkg::*;
();
   typedef struct packed {
      logic [7:0] d;
      logic [3:0] cfg; // parity en, odd, flip, stop
      logic [7:0] st;
   } row_t;
   row_t rows [6] = '{'{8'h55, 4'h1, 8'h01}, '{8'ha3, 4'h9, 8'h01}, '{8'ha3, 4'hd, 8'h01},
                      '{8'h3c, 4'hb, 8'h11}, '{8'h81, 4'he, 8'h21}, '{8'hff, 4'h0, 8'h21}};
   logic       clk = 1'b0, rst_b = 1'b0, rx_bit = 1'b1, rx_bit_valid = 1'b0;
   logic       carrier_detect = 1'b0, char_parity_en = 1'b0, char_parity_odd = 1'b0;
   logic       clear_error_command = 1'b0, do_init = 1'b0, auto_clear = 1'b1;
   logic [7:0] clear_error_arg = 8'h00;
   logic [3:0] char_data_bits = 4'h8;
   rx_mode_t   rx_mode = MODE_SYNC;
   logic       host_we, receive_irq, error_irq, rx_init;
   logic [4:0] host_addr;
   logic [7:0] host_wdata, host_rdata, system_error_byte, last_status, last_data;
   logic [11:0] f;
   int         n_seen, n_mismatch = 0, n_tests = 0, n_err = 0, want = 0;
   always #10 clk = ~clk;
   always @(negedge clk) if (error_irq === 1'b1) n_err++;
   rx_parallel_buffer_deframer uut (.clk(clk), .rst_b(rst_b), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid), .carrier_detect(carrier_detect), .rx_mode(rx_mode),
      .char_data_bits(char_data_bits), .char_parity_en(char_parity_en),
      .char_parity_odd(char_parity_odd), .rx_init(rx_init),
      .clear_error_command(clear_error_command), .clear_error_arg(clear_error_arg),
      .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .system_error_byte(system_error_byte),
      .receive_irq(receive_irq), .error_irq(error_irq));
   host_model host (.clk(clk), .receive_irq(receive_irq), .host_rdata(host_rdata),
      .do_init(do_init), .auto_clear(auto_clear), .host_we(host_we), .host_addr(host_addr),
      .host_wdata(host_wdata), .rx_init(rx_init), .last_status(last_status),
      .last_data(last_data), .n_seen(n_seen));
   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic end_of_test;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   task automatic send(input logic [63:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         rx_bit       = v[i];
         rx_bit_valid = 1'b1;
      end
      @(negedge clk);
      rx_bit_valid = 1'b0;
   endtask : send
   task automatic served(input int w);
      for (int k = 0; k < 40 && n_seen < w; k++)
         @(negedge clk);
      check("served", 8'(n_seen), 8'(w));
   endtask : served
   task automatic start(input rx_mode_t m);
      carrier_detect = 1'b0;
      @(negedge clk);
      rx_mode = m;
      do_init = 1'b1;
      @(negedge clk);
      do_init = 1'b0;
      repeat (12) @(negedge clk);
      carrier_detect = 1'b1;
      repeat (2) @(negedge clk);
   endtask : start
   task automatic clr(input logic [7:0] a);
      @(negedge clk);
      clear_error_arg     = a;
      clear_error_command = 1'b1;
      @(negedge clk);
      clear_error_command = 1'b0;
      @(negedge clk);
   endtask : clr
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      check("rdata", host_rdata, STATUS_RESET);
      check("system_error_byte", system_error_byte, SYSTEM_ERROR_BYTE_RESET);
      start(MODE_UART);
      foreach (rows[i]) begin
         char_parity_en  = rows[i].cfg[3];
         char_parity_odd = rows[i].cfg[2];
         f = rows[i].cfg[3] ?
             {1'b1, rows[i].cfg[0], ^rows[i].d ^ rows[i].cfg[2] ^ rows[i].cfg[1], rows[i].d, 1'b0}
             : {2'b11, rows[i].cfg[0], rows[i].d, 1'b0};
         send({52'h0, f}, 12);
         want++;
         served(want);
         check("status", last_status, rows[i].st);
         check("char", last_data, rows[i].d);
      end
      char_parity_en = 1'b0;
      send(64'h0, 40);
      send(64'hff, 8);
      repeat (20) @(negedge clk);
      want++;
      served(want);
      check("break", last_status, 8'h31);
      char_data_bits = 4'h7;
      send(64'h782, 11);
      want++;
      served(want);
      check("status", last_status, 8'h01);
      check("char7", last_data, 8'h41);
      char_data_bits = 4'h8;
      auto_clear = 1'b0;
      repeat (3) send(64'heaa, 12);
      repeat (20) @(negedge clk);
      want += 2;
      served(want);
      check("system_error_byte", system_error_byte, 8'h00);
      auto_clear = 1'b1;
      start(MODE_SYNC);
      send(64'h0123456789abcdef, 64);
      want++;
      served(want);
      check("status", last_status, 8'h08);
      check("data", last_data, 8'hef);
      send(64'hfedcba9876543210, 64);
      want++;
      served(want);
      check("data", last_data, 8'h10);
      auto_clear = 1'b0;
      repeat (3) send(64'h5a5a5a5a5a5a5a5a, 64);
      repeat (4) @(negedge clk);
      want += 2;
      served(want);
      check("system_error_byte", system_error_byte, 8'h02);
      check("err_irq", 8'(n_err), 8'h01);
      send(64'h5a5a5a5a5a5a5a5a, 64);
      repeat (10) @(negedge clk);
      served(want);
      clr(8'h01);
      check("system_error_byte", system_error_byte, 8'h02);
      clr(CLEAR_RX_ARG);
      check("system_error_byte", system_error_byte, 8'h00);
      auto_clear = 1'b1;
      start(MODE_SYNC);
      send(64'hab5, 12);
      carrier_detect = 1'b0;
      want++;
      served(want);
      check("status", last_status, 8'h02);
      check("data", last_data, 8'hb5);
      send(64'hff, 8);
      repeat (10) @(negedge clk);
      served(want);
      start(MODE_HDLC);
      send({36'h0, 20'hfffff, 8'h7e}, 28);
      repeat (20) @(negedge clk);
      want++;
      served(want);
      check("abort", last_status, 8'hb0);
      send(64'h7e7e7e7e, 32);
      repeat (10) @(negedge clk);
      served(want);
      send({20'h0, 8'h7e, 28'h1234567, 8'h7e}, 44);
      want++;
      served(want);
      check("frame", last_status, 8'he2);
      check("data", last_data, 8'h67);
      send({24'h0, 8'h7e, 24'hf07800, 8'h7e}, 40);
      want++;
      served(want);
      check("frame", last_status, 8'hc1);
      check("data", last_data, 8'h00);
      send({24'h0, 8'h7e, 24'hf07801, 8'h7e}, 40);
      want++;
      served(want);
      check("frame", last_status, 8'hd1);
      send({24'h0, 8'h7f, 24'h0, 8'h7e}, 40);
      want++;
      served(want);
      check("abort", last_status, 8'hf1);
      send(64'h7e, 8);
      send(64'h0, 64);
      send(64'h0, 24);
      want++;
      served(want);
      check("first", last_status, 8'h48);
      send(64'h7e, 8);
      want++;
      served(want);
      check("last", last_status, 8'h91);
      end_of_test();
   end
endmodule : rx_parallel_buffer_deframer_tb

// ### verilog/rx_parallel_buffer_deframer.sv
// Operation
// - a sync or in-frame hdlc buffer fill while next buffer status is non-empty is an overflow
// - overflow sets rx error bit and error irq; cleared by clear command arg 02
// - overflow counts always in sync, only inside frames in hdlc, never in uart
// - sync bits stored unmodified from bit 0 of first byte of buffer 0
// - sync length is always eight unless carrier drops mid buffer
// - status byte written on the same clock edge that raises the receive irq
// - length field bits 3..0 holds 0 to 8; sync upper bits zero
// - hdlc flags alone write nothing; adjacent flags may share a zero
// - hdlc deletes stuffed zeros, runs crc, marks first full buffer as start
// - closing flag checks crc, writes last data, sets end bit and error
// - hdlc errors in bits 5..4, start bit 6, end bit 7, abort highest
// - data bit count not a multiple of eight flags non-aligned
// - seven or more ones inside a frame report an aborted frame
// - more than seven ones between frames give exactly one abort report
// - uart ignores idle ones, start bit begins character, then write status
// - uart errors parity 01, stop 10, break 11, break wins over stop
// - stop error when bit after data or parity is zero; only first stop checked
// - break reported once however long it lasts
// - uart length is 0 empty or 1 for one character
// - on carrier detect writing begins in buffer zero
// - on carrier loss buffer updates stop until reinitialisation
// - buffer index starts at zero and toggles after each filled buffer
`timescale 1ns/100ps
module rx_parallel_buffer_deframer
   import rx_deframer_pkg::*;
(
   input  wire logic       clk,                // 50 MHz clock
   input  wire logic       rst_b,              // async reset
   input  wire logic       rx_bit,             // demodulated bit
   input  wire logic       rx_bit_valid,       // bit strobe
   input  wire logic       carrier_detect,     // carrier present
   input  wire rx_mode_t   rx_mode,            // sync, hdlc or uart
   input  wire logic [3:0] char_data_bits,     // uart data bits 5..8
   input  wire logic       char_parity_en,     // uart parity present
   input  wire logic       char_parity_odd,    // uart odd parity
   input  wire logic       rx_init,            // host init done pulse
   input  wire logic       clear_error_command,// clear error strobe
   input  wire logic [7:0] clear_error_arg,    // clear error argument
   input  wire logic       host_we,            // host write strobe
   input  wire logic [4:0] host_addr,          // host byte address
   input  wire logic [7:0] host_wdata,         // host write data
   output logic      [7:0] host_rdata,         // host read data
   output logic      [7:0] system_error_byte,  // error flags
   output logic            receive_irq,        // buffer filled pulse
   output logic            error_irq           // overflow pulse
);
   logic              run_reg, armed_reg, idx_reg, rx_irq_reg, err_irq_reg;
   logic        [7:0] system_error_byte_reg, rdata_reg, rd_mux;
   logic        [7:0] status_reg [2];
   logic        [7:0] data_reg [16];
   logic       [63:0] acc_reg, acc_next, acc_ins, fill_data;
   logic        [6:0] nbit_reg, nbit_next;
   logic        [3:0] ones_reg, ones_next, len_part;
   logic       [21:0] line_reg, line_next;
   logic        [4:0] pcnt_reg, pcnt_next, off0, off1;
   logic        [2:0] fcnt_reg, fcnt_next;
   logic       [15:0] crc_reg, crc_next, crc_step;
   logic              hunt_reg, hunt_next, first_reg, first_next;
   uart_state_t       ust_reg, ust_next;
   logic              par_reg, par_next, perr_reg, perr_next;
   logic              allz_reg, allz_next, brk_reg, brk_next;
   logic              fill_req, fill_frame, push;
   logic        [7:0] fill_stat;
   logic        [1:0] close_err, uart_err;
   logic              bit_in, start, cd_lost, busy, overflow, do_fill, ins_bit, clear_rx;

   assign bit_in   = run_reg & carrier_detect & rx_bit_valid;
   assign start    = armed_reg & carrier_detect & ~run_reg;
   assign cd_lost  = run_reg & ~carrier_detect;
   assign busy     = status_reg[idx_reg] != STATUS_RESET;
   assign overflow = fill_req & busy & fill_frame;
   assign do_fill  = fill_req & ~busy;
   assign clear_rx = clear_error_command & (clear_error_arg == CLEAR_RX_ARG);
   assign ins_bit  = (rx_mode == MODE_HDLC) ? line_reg[0] : rx_bit;
   assign len_part = nbit_reg[6:3] + {3'b000, |nbit_reg[2:0]};
   assign crc_step = {1'b0, crc_reg[15:1]}
                     ^ ((crc_reg[0] ^ line_reg[CRC_TAP]) ? CRC_POLY : 16'h0000);
   assign close_err = (fcnt_reg != ALIGN_PHASE) ? ERR_ALIGN :
                      (crc_reg != CRC_GOOD) ? ERR_CRC : ERR_NONE;
   assign uart_err = (allz_reg & ~rx_bit) ? ERR_BREAK :
                     ~rx_bit ? ERR_STOP :
                     perr_reg ? ERR_PARITY : ERR_NONE;

   always_comb begin
      acc_ins = acc_reg;
      acc_ins[nbit_reg[5:0]] = ins_bit;
   end

   always_comb begin
      acc_next = acc_reg;
      nbit_next = nbit_reg;
      ones_next = ones_reg;
      line_next = line_reg;
      pcnt_next = pcnt_reg;
      fcnt_next = fcnt_reg;
      crc_next = crc_reg;
      hunt_next = hunt_reg;
      first_next = first_reg;
      ust_next = ust_reg;
      par_next = par_reg;
      perr_next = perr_reg;
      allz_next = allz_reg;
      brk_next = brk_reg;
      fill_req = 1'b0;
      fill_frame = 1'b0;
      fill_stat = STATUS_RESET;
      fill_data = acc_reg;
      push = 1'b0;
      if (start) begin
         acc_next = '0;
         nbit_next = '0;
         ones_next = '0;
         line_next = '0;
         pcnt_next = '0;
         fcnt_next = '0;
         crc_next = CRC_INIT;
         hunt_next = 1'b1;
         first_next = 1'b1;
         ust_next = U_IDLE;
         brk_next = 1'b0;
      end else if (cd_lost) begin
         // partial sync buffer is handed over before stopping
         if (rx_mode == MODE_SYNC && nbit_reg != '0) begin
            fill_req = 1'b1;
            fill_frame = 1'b1;
            fill_stat = {4'h0, len_part};
         end
      end else if (bit_in) begin
         unique case (rx_mode)
            MODE_SYNC: begin
               acc_next = acc_ins;
               nbit_next = nbit_reg + 7'h01;
               if (nbit_reg == ACC_BITS - 7'h01) begin
                  fill_req = 1'b1;
                  fill_frame = 1'b1;
                  fill_stat = {4'h0, FULL_BYTES};
                  fill_data = acc_ins;
                  acc_next = '0;
                  nbit_next = '0;
               end
            end
            MODE_HDLC: begin
               if (rx_bit) begin
                  ones_next = (ones_reg == HUNT_ONES) ? ones_reg : ones_reg + 4'h1;
                  if (ones_reg < STUFF_ONES) begin
                     push = ~hunt_reg;
                  end else if (ones_reg == FLAG_ONES && !hunt_reg && pcnt_reg > FLAG_TAIL) begin
                     fill_req = 1'b1;
                     fill_frame = 1'b1;
                     fill_stat = {1'b1, first_reg, ERR_ABORT, len_part};
                     hunt_next = 1'b1;
                  end else if (ones_reg == ABORT_ONES && !hunt_reg) begin
                     fill_req = 1'b1;
                     fill_stat = {1'b1, 1'b0, ERR_ABORT, 4'h0};
                     hunt_next = 1'b1;
                  end
               end else begin
                  ones_next = '0;
                  if (ones_reg == FLAG_ONES) begin
                     // flag: its leading zero and first five ones were pushed into the line
                     if (!hunt_reg && pcnt_reg > FLAG_TAIL) begin
                        fill_req = 1'b1;
                        fill_frame = 1'b1;
                        fill_stat = {1'b1, first_reg, close_err, len_part};
                     end
                     acc_next = '0;
                     nbit_next = '0;
                     line_next = '0;
                     pcnt_next = '0;
                     fcnt_next = '0;
                     crc_next = CRC_INIT;
                     hunt_next = 1'b0;
                     first_next = 1'b1;
                  end else if (ones_reg < STUFF_ONES) begin
                     push = ~hunt_reg;
                  end
               end
               if (push) begin
                  line_next = {rx_bit, line_reg[21:1]};
                  pcnt_next = (pcnt_reg == LINE_BITS) ? pcnt_reg : pcnt_reg + 5'h01;
                  fcnt_next = fcnt_reg + 3'h1;
                  if (pcnt_reg >= FLAG_TAIL) begin
                     crc_next = crc_step;
                  end
                  if (pcnt_reg == LINE_BITS) begin
                     // fcs and flag tail stay in the line, out of the data
                     if (nbit_reg == ACC_BITS) begin
                        fill_req = 1'b1;
                        fill_frame = 1'b1;
                        fill_stat = {1'b0, first_reg, ERR_NONE, FULL_BYTES};
                        first_next = 1'b0;
                        acc_next = {63'h0, line_reg[0]};
                        nbit_next = 7'h01;
                     end else begin
                        acc_next = acc_ins;
                        nbit_next = nbit_reg + 7'h01;
                     end
                  end
               end
            end
            MODE_UART: begin
               unique case (ust_reg)
                  U_IDLE: begin
                     if (brk_reg) begin
                        brk_next = ~rx_bit;
                     end else if (!rx_bit) begin
                        ust_next = U_DATA;
                        acc_next = '0;
                        nbit_next = '0;
                        par_next = 1'b0;
                        perr_next = 1'b0;
                        allz_next = 1'b1;
                     end
                  end
                  U_DATA: begin
                     acc_next = acc_ins;
                     nbit_next = nbit_reg + 7'h01;
                     par_next = par_reg ^ rx_bit;
                     allz_next = allz_reg & ~rx_bit;
                     if (nbit_reg[3:0] == char_data_bits - 4'h1) begin
                        ust_next = char_parity_en ? U_PARITY : U_STOP;
                     end
                  end
                  U_PARITY: begin
                     perr_next = par_reg ^ rx_bit ^ char_parity_odd;
                     allz_next = allz_reg & ~rx_bit;
                     ust_next = U_STOP;
                  end
                  U_STOP: begin
                     fill_req = 1'b1;
                     fill_stat = {2'b00, uart_err, ONE_CHAR};
                     brk_next = allz_reg & ~rx_bit;
                     ust_next = U_IDLE;
                  end
               endcase
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_reg <= 1'b0;
         armed_reg <= 1'b0;
         idx_reg <= 1'b0;
         rx_irq_reg <= 1'b0;
         err_irq_reg <= 1'b0;
         system_error_byte_reg <= SYSTEM_ERROR_BYTE_RESET;
      end else begin
         rx_irq_reg <= do_fill;
         err_irq_reg <= overflow;
         if (rx_init) begin
            armed_reg <= 1'b1;
            run_reg <= 1'b0;
         end else if (start) begin
            armed_reg <= 1'b0;
            run_reg <= 1'b1;
         end else if (cd_lost | overflow) begin
            run_reg <= 1'b0;
         end
         if (start) begin
            idx_reg <= 1'b0;
         end else if (do_fill) begin
            idx_reg <= ~idx_reg;
         end
         if (overflow) begin
            system_error_byte_reg[SYSTEM_ERROR_BYTE_RX_BIT] <= 1'b1;
         end else if (clear_rx) begin
            system_error_byte_reg[SYSTEM_ERROR_BYTE_RX_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_reg <= '0;
         nbit_reg <= '0;
         ones_reg <= '0;
         line_reg <= '0;
         pcnt_reg <= '0;
         fcnt_reg <= '0;
         crc_reg <= CRC_INIT;
         hunt_reg <= 1'b1;
         first_reg <= 1'b1;
         ust_reg <= U_IDLE;
         par_reg <= 1'b0;
         perr_reg <= 1'b0;
         allz_reg <= 1'b0;
         brk_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         nbit_reg <= nbit_next;
         ones_reg <= ones_next;
         line_reg <= line_next;
         pcnt_reg <= pcnt_next;
         fcnt_reg <= fcnt_next;
         crc_reg <= crc_next;
         hunt_reg <= hunt_next;
         first_reg <= first_next;
         ust_reg <= ust_next;
         par_reg <= par_next;
         perr_reg <= perr_next;
         allz_reg <= allz_next;
         brk_reg <= brk_next;
      end
   end

   // device fill wins over a host write to the same status byte
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg[0] <= STATUS_RESET;
         status_reg[1] <= STATUS_RESET;
         for (int i = 0; i < 16; i++) begin
            data_reg[i] <= BYTE_RESET;
         end
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (do_fill && idx_reg == b[0]) begin
               status_reg[b] <= fill_stat;
            end else if (host_we && host_addr == (b == 0 ? STATUS0_ADDR : STATUS1_ADDR)) begin
               status_reg[b] <= host_wdata;
            end
         end
         if (do_fill) begin
            for (int k = 0; k < 8; k++) begin
               data_reg[{idx_reg, k[2:0]}] <= fill_data[8*k +: 8];
            end
         end
      end
   end

   assign off0 = host_addr - DATA0_ADDR;
   assign off1 = host_addr - DATA1_ADDR;
   assign rd_mux = (host_addr == STATUS0_ADDR) ? status_reg[0] :
                   (host_addr == STATUS1_ADDR) ? status_reg[1] :
                   (off0 < 5'h08) ? data_reg[{1'b0, off0[2:0]}] :
                   (off1 < 5'h08) ? data_reg[{1'b1, off1[2:0]}] : 8'h00;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rd_mux;
      end
   end

   assign host_rdata = rdata_reg;
   assign system_error_byte = system_error_byte_reg;
   assign receive_irq = rx_irq_reg;
   assign error_irq = err_irq_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   ovf_sets_error_a: assert property (overflow |=> system_error_byte_reg[SYSTEM_ERROR_BYTE_RX_BIT] && error_irq)
      else $error("overflow did not raise error");
   error_held_a: assert property (system_error_byte_reg[SYSTEM_ERROR_BYTE_RX_BIT] && !clear_rx |=> system_error_byte_reg[SYSTEM_ERROR_BYTE_RX_BIT])
      else $error("rx error flag dropped without clear");
   uart_no_ovf_a: assert property (rx_mode == MODE_UART |-> !overflow)
      else $error("overflow in uart mode");
   status_then_irq_a: assert property (do_fill |=> receive_irq && status_reg[$past(idx_reg)] != 8'h00)
      else $error("irq without written status");
   sync_len_eight_a: assert property (do_fill && rx_mode == MODE_SYNC && !cd_lost |-> fill_stat == 8'h08)
      else $error("sync buffer length not eight");
   uart_len_one_a: assert property (do_fill && rx_mode == MODE_UART |-> fill_stat[7:6] == 2'b00 && fill_stat[3:0] == 4'h1)
      else $error("uart status length wrong");
   start_buf_zero_a: assert property (start |=> run_reg && !idx_reg)
      else $error("reception did not start at buffer zero");
   index_toggle_a: assert property (do_fill |=> idx_reg != $past(idx_reg))
      else $error("buffer index did not toggle");
   carrier_stop_a: assert property (!run_reg |-> !fill_req)
      else $error("updates continued after carrier loss");
   break_once_a: assert property (do_fill && rx_mode == MODE_UART && fill_stat[5:4] == ERR_BREAK |=> brk_reg)
      else $error("break hold not armed");
endmodule : rx_parallel_buffer_deframer
